// ---- src/ctx_regs.vh ----
// register map, field positions, reset values and frame constants of the can transmit block
`ifndef CTX_REGS_VH
`define CTX_REGS_VH

// ************************************************************
// register byte offsets (wishbone byte address, one word each)
// ************************************************************
`define CTX_OFS_CTRL0 8'h00
`define CTX_OFS_CTRL1 8'h04
`define CTX_OFS_BTR0 8'h08
`define CTX_OFS_BTR1 8'h0C
`define CTX_OFS_RFLG 8'h10
`define CTX_OFS_RIER 8'h14
`define CTX_OFS_TFLG 8'h18
`define CTX_OFS_TIER 8'h1C
`define CTX_OFS_TARQ 8'h20
`define CTX_OFS_TAAK 8'h24
`define CTX_OFS_TBSEL 8'h28
`define CTX_OFS_IDAC 8'h2C
// filter code 0x40..0x5C, filter mask 0x60..0x7C, selected by adr[7:6]
`define CTX_FILT_PAGE 2'h1
// shared transmit window 0x80..0xBC, selected by adr[7:6]
`define CTX_WIN_PAGE 2'h2

// ************************************************************
// field positions
// ************************************************************
`define CTX_CTRL0_INIT_REQ 0
`define CTX_CTRL0_SLEEP_REQ 1
`define CTX_CTRL0_TIME 3
`define CTX_CTRL1_INIT_ACK 0
`define CTX_CTRL1_SLEEP_ACK 1

// ************************************************************
// slot layout: 13 message bytes, priority, two stamp bytes
// ************************************************************
`define CTX_SLOT_BYTES 16
`define CTX_MSG_BYTES 4'hD
`define CTX_WIN_RANK 4'hD
`define CTX_WIN_TSH 4'hE
`define CTX_WIN_TSL 4'hF

// ************************************************************
// reset values
// ************************************************************
`define CTX_RST_INIT_REQ 1'b1
`define CTX_RST_EMPTY 1'b1
`define CTX_RST_BYTE 8'h00
`define CTX_RST_SEL 3'h0

// ************************************************************
// frame timing: start bit plus 13 bytes, and bit period terms
// ************************************************************
`define CTX_FRAME_BITS 7'h69
`define CTX_SEG_EXTRA 5'h03

`endif

// ---- src/ctx_tx_slot.v ----
// one transmit slot: message bytes, local priority, time stamp, empty and abort-ack flags
`timescale 1ns/10ps
`include "ctx_regs.vh"

module ctx_tx_slot #(
   parameter BYTES = `CTX_SLOT_BYTES
) (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire init,
   // bus side
   input wire wr_en,
   input wire [3:0] wr_idx,
   input wire [7:0] wr_data,
   input wire clr_empty,
   input wire [3:0] bus_idx,
   output wire [7:0] bus_byte,
   // engine side
   input wire set_empty,
   input wire set_abort_ack,
   input wire ts_load,
   input wire [15:0] ts_val,
   input wire [3:0] eng_idx,
   output wire [7:0] eng_byte,
   // status
   output wire [7:0] rank,
   output wire empty,
   output wire abort_ack
);

   reg [7:0] mem_r [0:BYTES-1];
   reg empty_r;
   reg abort_ack_r;
   integer i;

   assign bus_byte = mem_r[bus_idx];
   assign eng_byte = mem_r[eng_idx];
   assign rank = mem_r[`CTX_WIN_RANK];
   assign empty = empty_r;
   assign abort_ack = abort_ack_r;

   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < BYTES; i = i + 1) begin
            mem_r[i] <= `CTX_RST_BYTE;
         end
         empty_r <= `CTX_RST_EMPTY;
         abort_ack_r <= 1'b0;
      end else begin
         if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
         end
         if (ts_load) begin
            mem_r[`CTX_WIN_TSH] <= ts_val[15:8];
            mem_r[`CTX_WIN_TSL] <= ts_val[7:0];
         end
         // hardware set beats a software clear in the same cycle
         if (init) begin
            empty_r <= `CTX_RST_EMPTY;
            abort_ack_r <= 1'b0;
         end else if (set_empty) begin
            empty_r <= 1'b1;
            abort_ack_r <= set_abort_ack;
         end else if (clr_empty) begin
            empty_r <= 1'b0;
            abort_ack_r <= 1'b0;
         end
      end
   end

endmodule

// ---- src/ctx_can_tx.v ----
// can controller transmit side: three queued slots, priority pick, serial send, init handshake
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "ctx_regs.vh"

// Function
// - three independent transmit slots, sent back to back from the queue
// - each slot holds a 13-byte message: identifier, control bits, data
// - each slot has an 8-bit local priority; best ready slot goes first
// - two more bytes per slot hold a time stamp when stamping is on
// - empty flag set by hardware marks a free slot; software picks only those
// - the selected slot appears in one shared transmit window
// - software loads then clears empty; clearing marks slot ready to send
// - entering init aborts transfer and drops bus synchronisation at once
// - in init the transmit pin is forced recessive immediately
// - in init the engine halts but registers remain accessible
// - init returns control, flag, enable, abort and select registers to default
// - bit timing and filter registers writable only in init mode
// - init request crosses to engine through a handshake; ack after all took it
// - ack comes at least two bus plus three engine cycles after request
// - init acknowledge sets only when every part has entered init
// - clearing init request is ignored until init acknowledge is set
// - time stamp counter is held at zero while init mode is active
module ctx_can_tx #(
   parameter SLOTS = 3,
   parameter FILT_REGS = 16
) (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // can transceiver
   input wire can_rx_pin,
   output reg can_tx_pin
);

   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;

   // ************************************************************
   // declarations
   // ************************************************************
   reg init_req_r;
   reg sleep_req_r;
   reg time_en_r;
   reg sleep_ack_r;
   reg can_s1_r;
   reg can_s2_r;
   reg can_init_r;
   reg ack_s1_r;
   reg ack_s2_r;
   reg init_ack_r;
   reg [7:0] btr0_r;
   reg [7:0] btr1_r;
   reg [7:0] rflg_r;
   reg [7:0] rier_r;
   reg [2:0] tier_r;
   reg [2:0] arq_r;
   reg [2:0] sel_r;
   reg [7:0] idac_r;
   reg [7:0] filt_r [0:FILT_REGS-1];
   reg rx_s1_r;
   reg rx_s2_r;
   reg eng_st_r;
   reg [1:0] eng_slot_r;
   reg [6:0] bit_idx_r;
   reg [11:0] bit_cnt_r;
   reg [15:0] ts_cnt_r;
   reg [7:0] rd_byte;
   reg pick_ok;
   reg [1:0] pick_idx;
   reg [7:0] best;
   reg [7:0] win_byte;
   reg [7:0] eng_byte;
   reg [2:0] sel_nxt;
   integer k;
   integer f;

   wire init_active;
   wire halt;
   wire wb_req;
   wire wr;
   wire win_hit;
   wire filt_hit;
   wire [3:0] filt_idx;
   wire [3:0] win_idx;
   wire win_wr;
   wire [2:0] empty;
   wire [2:0] aak;
   wire [2:0] rdy;
   wire [2:0] abort_go;
   wire [2:0] done_vec;
   wire [23:0] rank_flat;
   wire [23:0] bus_flat;
   wire [23:0] eng_flat;
   wire [6:0] tq_w;
   wire [4:0] seg_w;
   wire [11:0] period_w;
   wire tick;
   wire [6:0] data_bit;
   wire [3:0] eng_idx;
   wire tx_bit;
   wire frame_end;
   wire lost_arb;

   // ************************************************************
   // wishbone decode
   // ************************************************************
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = wb_req & wb_we_i & wb_sel_i[0];
   assign win_hit = (wb_adr_i[7:6] == `CTX_WIN_PAGE);
   assign filt_hit = (wb_adr_i[7:6] == `CTX_FILT_PAGE);
   assign filt_idx = wb_adr_i[5:2];
   assign win_idx = wb_adr_i[5:2];
   // stamp bytes are read-only, and only a free selected slot takes data
   assign win_wr = wr & win_hit & (win_idx < `CTX_WIN_TSH) & ((sel_r & empty) != 3'h0);
   assign init_active = init_req_r & init_ack_r;
   // the pin and engine react to the request itself, not to the slower ack
   assign halt = init_req_r | can_init_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= {24'h0, rd_byte};
         end
      end
   end

   always @* begin
      win_byte = bus_flat[7:0];
      for (k = 0; k < SLOTS; k = k + 1) begin
         if (sel_r[k]) begin
            win_byte = bus_flat[k*8 +: 8];
         end
      end
      rd_byte = 8'h0;
      if (win_hit) begin
         rd_byte = win_byte;
      end else if (filt_hit) begin
         rd_byte = filt_r[filt_idx];
      end else begin
         case (wb_adr_i)
            `CTX_OFS_CTRL0: rd_byte = {4'h0, time_en_r, 1'b0, sleep_req_r, init_req_r};
            `CTX_OFS_CTRL1: rd_byte = {6'h0, sleep_ack_r, init_ack_r};
            `CTX_OFS_BTR0: rd_byte = btr0_r;
            `CTX_OFS_BTR1: rd_byte = btr1_r;
            `CTX_OFS_RFLG: rd_byte = rflg_r;
            `CTX_OFS_RIER: rd_byte = rier_r;
            `CTX_OFS_TFLG: rd_byte = {5'h0, empty};
            `CTX_OFS_TIER: rd_byte = {5'h0, tier_r};
            `CTX_OFS_TARQ: rd_byte = {5'h0, arq_r};
            `CTX_OFS_TAAK: rd_byte = {5'h0, aak};
            `CTX_OFS_TBSEL: rd_byte = {5'h0, sel_r};
            `CTX_OFS_IDAC: rd_byte = idac_r;
            default: rd_byte = 8'h0;
         endcase
      end
   end

   // ************************************************************
   // selection: lowest free slot among those written as one
   // ************************************************************
   always @* begin
      sel_nxt = 3'h0;
      for (k = SLOTS - 1; k >= 0; k = k - 1) begin
         if (wb_dat_i[k] & empty[k]) begin
            sel_nxt = 3'h0;
            sel_nxt[k] = 1'b1;
         end
      end
   end

   // ************************************************************
   // control and configuration registers
   // ************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         init_req_r <= `CTX_RST_INIT_REQ;
         sleep_req_r <= 1'b0;
         time_en_r <= 1'b0;
         rflg_r <= `CTX_RST_BYTE;
         rier_r <= `CTX_RST_BYTE;
         tier_r <= 3'h0;
         sel_r <= `CTX_RST_SEL;
         btr0_r <= `CTX_RST_BYTE;
         btr1_r <= `CTX_RST_BYTE;
         idac_r <= `CTX_RST_BYTE;
         for (f = 0; f < FILT_REGS; f = f + 1) begin
            filt_r[f] <= `CTX_RST_BYTE;
         end
      end else begin
         if (wr && wb_adr_i == `CTX_OFS_CTRL0) begin
            // a clear is only honoured once the ack confirms init mode
            if (wb_dat_i[`CTX_CTRL0_INIT_REQ] || init_ack_r) begin
               init_req_r <= wb_dat_i[`CTX_CTRL0_INIT_REQ];
            end
         end
         if (init_active) begin
            sleep_req_r <= 1'b0;
            time_en_r <= 1'b0;
            rflg_r <= `CTX_RST_BYTE;
            rier_r <= `CTX_RST_BYTE;
            tier_r <= 3'h0;
            sel_r <= `CTX_RST_SEL;
            if (wr && wb_adr_i == `CTX_OFS_BTR0) begin
               btr0_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `CTX_OFS_BTR1) begin
               btr1_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `CTX_OFS_IDAC) begin
               idac_r <= wb_dat_i[7:0];
            end
            if (wr && filt_hit) begin
               filt_r[filt_idx] <= wb_dat_i[7:0];
            end
         end else begin
            // configuration writes fall through here and are dropped
            if (wr && wb_adr_i == `CTX_OFS_CTRL0) begin
               sleep_req_r <= wb_dat_i[`CTX_CTRL0_SLEEP_REQ];
               time_en_r <= wb_dat_i[`CTX_CTRL0_TIME];
            end
            if (wr && wb_adr_i == `CTX_OFS_RFLG) begin
               rflg_r <= rflg_r & ~wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `CTX_OFS_RIER) begin
               rier_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `CTX_OFS_TIER) begin
               tier_r <= wb_dat_i[2:0];
            end
            if (wr && wb_adr_i == `CTX_OFS_TBSEL) begin
               sel_r <= sel_nxt;
            end
         end
      end
   end

   // abort requests stand until the slot reads empty
   always @(posedge ref_clk) begin
      if (rst || init_active) begin
         arq_r <= 3'h0;
      end else if (wr && wb_adr_i == `CTX_OFS_TARQ) begin
         arq_r <= (arq_r | wb_dat_i[2:0]) & ~empty;
      end else begin
         arq_r <= arq_r & ~empty;
      end
   end

   // ************************************************************
   // init handshake: three engine-side stages, three back to the bus side
   // ************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         can_s1_r <= 1'b0;
         can_s2_r <= 1'b0;
         can_init_r <= 1'b0;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         init_ack_r <= 1'b0;
      end else begin
         can_s1_r <= init_req_r;
         can_s2_r <= can_s1_r;
         can_init_r <= can_s2_r;
         ack_s1_r <= can_init_r;
         ack_s2_r <= ack_s1_r;
         init_ack_r <= ack_s2_r & init_req_r;
      end
   end

   // ************************************************************
   // transmit slots
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < SLOTS; g = g + 1) begin : slot
         ctx_tx_slot #(
            .BYTES(`CTX_SLOT_BYTES)
         ) u_slot (
            .clk(ref_clk),
            .rst(rst),
            .init(init_active),
            .wr_en(win_wr & sel_r[g]),
            .wr_idx(win_idx),
            .wr_data(wb_dat_i[7:0]),
            .clr_empty(wr && wb_adr_i == `CTX_OFS_TFLG && wb_dat_i[g]),
            .bus_idx(win_idx),
            .bus_byte(bus_flat[g*8 +: 8]),
            .set_empty(done_vec[g] | abort_go[g]),
            .set_abort_ack(abort_go[g]),
            .ts_load(done_vec[g] & time_en_r),
            .ts_val(ts_cnt_r),
            .eng_idx(eng_idx),
            .eng_byte(eng_flat[g*8 +: 8]),
            .rank(rank_flat[g*8 +: 8]),
            .empty(empty[g]),
            .abort_ack(aak[g])
         );
         assign rdy[g] = ~empty[g] & ~arq_r[g];
         assign abort_go[g] = arq_r[g] & ~empty[g] & ~(eng_st_r == ST_SEND && eng_slot_r == g);
         assign done_vec[g] = frame_end & (eng_slot_r == g);
      end
   endgenerate

   // lowest priority value wins, ties go to the lower slot
   always @* begin
      pick_ok = 1'b0;
      pick_idx = 2'h0;
      best = 8'hFF;
      for (k = 0; k < SLOTS; k = k + 1) begin
         if (rdy[k] && (!pick_ok || rank_flat[k*8 +: 8] < best)) begin
            pick_ok = 1'b1;
            pick_idx = k[1:0];
            best = rank_flat[k*8 +: 8];
         end
      end
   end

   // ************************************************************
   // bit timing, time stamp counter and serial engine
   // ************************************************************
   assign tq_w = {1'b0, btr0_r[5:0]} + 7'h01;
   assign seg_w = {1'b0, btr1_r[3:0]} + {2'h0, btr1_r[6:4]} + `CTX_SEG_EXTRA;
   assign period_w = {5'h0, tq_w} * {7'h0, seg_w};
   assign tick = (bit_cnt_r == period_w - 12'h001);
   assign data_bit = bit_idx_r - 7'h01;
   assign eng_idx = data_bit[6:3];
   always @* begin
      eng_byte = eng_flat[7:0];
      for (k = 0; k < SLOTS; k = k + 1) begin
         if (eng_slot_r == k) begin
            eng_byte = eng_flat[k*8 +: 8];
         end
      end
   end
   // start bit is dominant, then message bytes msb first; no stuffing or crc here
   assign tx_bit = (bit_idx_r == 7'h00) ? 1'b0 : eng_byte[3'h7 - data_bit[2:0]];
   assign frame_end = (eng_st_r == ST_SEND) & tick & (bit_idx_r == `CTX_FRAME_BITS - 7'h01) & ~halt;
   // the pin register plus two input stages lag three cycles; a bit lasts at least three cycles
   assign lost_arb = (eng_st_r == ST_SEND) & tick & tx_bit & ~rx_s2_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= can_rx_pin;
         rx_s2_r <= rx_s1_r;
      end
   end

   always @(posedge ref_clk) begin
      if (rst || can_init_r) begin
         ts_cnt_r <= 16'h0;
      end else if (tick) begin
         ts_cnt_r <= ts_cnt_r + 16'h0001;
      end
   end

   always @(posedge ref_clk) begin
      if (rst || halt) begin
         eng_st_r <= ST_IDLE;
         eng_slot_r <= 2'h0;
         bit_idx_r <= 7'h00;
         bit_cnt_r <= 12'h000;
         can_tx_pin <= 1'b1;
         sleep_ack_r <= 1'b0;
      end else begin
         bit_cnt_r <= tick ? 12'h000 : bit_cnt_r + 12'h001;
         sleep_ack_r <= sleep_req_r & (eng_st_r == ST_IDLE);
         case (eng_st_r)
            ST_IDLE: begin
               can_tx_pin <= 1'b1;
               bit_idx_r <= 7'h00;
               // next frame starts after one idle cycle while slots stay ready
               if (pick_ok && !sleep_req_r) begin
                  eng_st_r <= ST_SEND;
                  eng_slot_r <= pick_idx;
                  bit_cnt_r <= 12'h000;
               end
            end
            ST_SEND: begin
               can_tx_pin <= tx_bit;
               if (lost_arb || frame_end) begin
                  eng_st_r <= ST_IDLE;
                  can_tx_pin <= 1'b1;
               end else if (tick) begin
                  bit_idx_r <= bit_idx_r + 7'h01;
               end
            end
            default: eng_st_r <= ST_IDLE;
         endcase
      end
   end

endmodule

// ---- testbench/ctx_can_tx_assertions.sv ----
// concurrent checks on the ports of the can transmit block
`timescale 1ns/10ps
`include "ctx_regs.vh"

module ctx_can_tx_checker (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // can pins
   input wire can_rx_pin,
   input wire can_tx_pin
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire init_set = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CTX_OFS_CTRL0) & wb_dat_i[0];
   wire ack_rd = take & ~wb_we_i & (wb_adr_i == `CTX_OFS_CTRL1);
   reg [3:0] since_r;
   // ************************************************************
   // edges since the last init request; saturates so it never wraps
   // ************************************************************
   always @(posedge ref_clk) begin
      if (rst | init_set) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
   end
   property p_ack_next; take |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(take); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_upper; wb_dat_o[31:8] == 24'h0; endproperty
   a_dat_upper: assert property (p_dat_upper) else $error("upper read lanes not zero");
   property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
   property p_unmapped; take && !wb_we_i && wb_adr_i == 8'h30 |=> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reset_pin; $fell(rst) |-> can_tx_pin [*6]; endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("pin dominant in init after reset");
   property p_init_pin; init_set |-> ##2 can_tx_pin [*6]; endproperty
   a_init_pin: assert property (p_init_pin) else $error("pin not recessive in init");
   property p_ack_min; ack_rd && since_r < 4'h4 |=> !wb_dat_o[0]; endproperty
   a_ack_min: assert property (p_ack_min) else $error("init ack too early");
   c_frame: cover property ($fell(can_tx_pin));
   c_init: cover property (init_set);
   c_early: cover property (ack_rd && since_r < 4'h4);
endmodule

bind ctx_can_tx ctx_can_tx_checker u_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .can_rx_pin, .can_tx_pin);

// ---- testbench/ctx_bus_node.sv ----
// far-side can node: wired-and bus level fed back to the receive pin
`timescale 1ns/10ps

module ctx_bus_node (
   // controller pins
   input wire can_tx_pin,
   output wire can_rx_pin,
   // other node drives dominant while high
   input wire other_dom
);
   // dominant wins on the wire; an undriven bus floats recessive through the bias
   assign can_rx_pin = can_tx_pin & ~other_dom;
endmodule

// ---- testbench/test_ctx_can_tx.sv ----
// self-checking bench for the can transmit block
`timescale 1ns/10ps
`include "ctx_regs.vh"

module test_ctx_can_tx;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic ref_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, other_dom = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, can_rx_pin, can_tx_pin;
   integer miscompares = 0, n_compared = 0;
   // bit period for prescaler field 1 and zero segments: (1+1)*(0+0+3)
   localparam int P = 6;
   always #20 ref_clk = ~ref_clk;
   ctx_can_tx dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin));
   ctx_bus_node u_node (.can_tx_pin(can_tx_pin), .can_rx_pin(can_rx_pin), .other_dom(other_dom));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic report_and_stop;
      begin
         $display("compared %0d, miscompares %0d", n_compared, miscompares);
         if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task automatic check(input logic [103:0] seen, input logic [103:0] exp);
      begin
         n_compared++;
         if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      integer n;
      begin
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (wb_ack_o !== 1'b1 && n < 20);
         q = wb_dat_o[7:0];
         {wb_cyc_i, wb_stb_i} <= 2'b00;
         @(posedge ref_clk);
         check(n < 20, 1'b1);
         if (n >= 20) report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      begin
         wb(1'b1, a, d, q);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      begin
         wb(1'b0, a, 8'h00, q);
         check(q, e);
      end
   endtask
   task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] q;
      integer n;
      begin
         n = 0;
         do begin
            wb(1'b0, a, 8'h00, q);
            n++;
         end while ((q & m) !== e && n < 400);
         check(q & m, e);
         if (n >= 400) report_and_stop();
      end
   endtask
   task automatic wait_start(input integer lim);
      integer n;
      begin
         n = 0;
         while (can_tx_pin !== 1'b0 && n < lim) begin
            @(posedge ref_clk);
            n++;
         end
         check(n < lim, 1'b1);
         if (n >= lim) report_and_stop();
      end
   endtask
   // samples each bit one bit period after the previous one, msb first
   task automatic rx_frame(input integer lim, output logic [103:0] b);
      integer n;
      begin
         wait_start(lim);
         for (n = 0; n < 104; n++) begin
            repeat (P) @(posedge ref_clk);
            b[103 - n] = can_tx_pin;
         end
         // let the last bit pass so a back-to-back start bit is not missed
         repeat (P) @(posedge ref_clk);
      end
   endtask
   task automatic load(input logic [7:0] base, input logic [7:0] rank);
      logic [7:0] i;
      begin
         for (i = 8'h00; i < `CTX_MSG_BYTES; i++) wr(8'h80 + (i << 2), base + i);
         wr(8'hB4, rank);
      end
   endtask
   function automatic logic [103:0] pat(input logic [7:0] base);
      integer i;
      begin
         pat = '0;
         for (i = 0; i < 13; i++) pat[103 - 8 * i -: 8] = base + 8'(i);
      end
   endfunction
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_init_entry;
      begin
         wr(`CTX_OFS_CTRL0, 8'h00);
         rdc(`CTX_OFS_CTRL0, 8'h01);
         poll(`CTX_OFS_CTRL1, 8'h01, 8'h01);
         rdc(`CTX_OFS_TFLG, 8'h07);
         rdc(`CTX_OFS_TBSEL, 8'h00);
         rdc(`CTX_OFS_TAAK, 8'h00);
         wr(`CTX_OFS_BTR0, 8'h01);
         wr(`CTX_OFS_IDAC, 8'h5A);
         wr(8'h44, 8'hC3);
         rdc(`CTX_OFS_BTR0, 8'h01);
         rdc(`CTX_OFS_IDAC, 8'h5A);
         rdc(8'h44, 8'hC3);
         wr(`CTX_OFS_CTRL0, 8'h00);
         poll(`CTX_OFS_CTRL1, 8'h01, 8'h00);
         wr(`CTX_OFS_CTRL0, 8'h08);
      end
   endtask
   task automatic t_rule21;
      begin
         wr(`CTX_OFS_BTR0, 8'h3F);
         wr(`CTX_OFS_IDAC, 8'h00);
         wr(8'h44, 8'h00);
         rdc(`CTX_OFS_BTR0, 8'h01);
         rdc(`CTX_OFS_IDAC, 8'h5A);
         rdc(8'h44, 8'hC3);
         rdc(8'h30, 8'h00);
      end
   endtask
   task automatic t_queue;
      logic [103:0] b;
      logic [7:0] q;
      begin
         wr(`CTX_OFS_TBSEL, 8'h07);
         rdc(`CTX_OFS_TBSEL, 8'h01);
         load(8'h50, 8'h20);
         rdc(8'h80, 8'h50);
         wr(`CTX_OFS_TBSEL, 8'h02);
         rdc(`CTX_OFS_TBSEL, 8'h02);
         rdc(8'h80, 8'h00);
         load(8'hA0, 8'h10);
         wr(`CTX_OFS_TFLG, 8'h03);
         rdc(`CTX_OFS_TFLG, 8'h04);
         rx_frame(20, b);
         check(b, pat(8'hA0));
         rx_frame(12, b);
         check(b, pat(8'h50));
         poll(`CTX_OFS_TFLG, 8'h07, 8'h07);
         wb(1'b0, 8'hBC, 8'h00, q);
         check(q != 8'h00, 1'b1);
      end
   endtask
   task automatic t_lost;
      logic [103:0] b;
      begin
         wr(`CTX_OFS_TBSEL, 8'h01);
         load(8'h60, 8'h00);
         wr(`CTX_OFS_TFLG, 8'h01);
         wait_start(20);
         other_dom <= 1'b1;
         // hold dominant over the first recessive data bit so arbitration is lost
         repeat (3 * P) @(posedge ref_clk);
         other_dom <= 1'b0;
         rx_frame(40, b);
         check(b, pat(8'h60));
         poll(`CTX_OFS_TFLG, 8'h07, 8'h07);
      end
   endtask
   task automatic t_init_abort;
      begin
         wr(`CTX_OFS_TBSEL, 8'h01);
         load(8'h30, 8'h00);
         wr(`CTX_OFS_TFLG, 8'h01);
         wait_start(20);
         wr(`CTX_OFS_CTRL0, 8'h09);
         check(can_tx_pin, 1'b1);
         poll(`CTX_OFS_CTRL1, 8'h01, 8'h01);
         rdc(`CTX_OFS_CTRL0, 8'h01);
         rdc(`CTX_OFS_TFLG, 8'h07);
         rdc(`CTX_OFS_TBSEL, 8'h00);
         wr(`CTX_OFS_TBSEL, 8'h01);
         rdc(`CTX_OFS_TBSEL, 8'h00);
         wr(`CTX_OFS_CTRL0, 8'h00);
         poll(`CTX_OFS_CTRL1, 8'h01, 8'h00);
      end
   endtask
   task automatic t_sleep_init;
      begin
         wr(`CTX_OFS_CTRL0, 8'h02);
         poll(`CTX_OFS_CTRL1, 8'h02, 8'h02);
         wr(`CTX_OFS_TFLG, 8'h04);
         wr(`CTX_OFS_TARQ, 8'h04);
         rdc(`CTX_OFS_TAAK, 8'h04);
         wr(`CTX_OFS_CTRL0, 8'h03);
         poll(`CTX_OFS_CTRL1, 8'h01, 8'h01);
         rdc(`CTX_OFS_CTRL0, 8'h01);
         rdc(`CTX_OFS_TAAK, 8'h00);
      end
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_init_entry();
      t_rule21();
      t_queue();
      t_lost();
      t_init_abort();
      t_sleep_init();
      report_and_stop();
   end
endmodule
